// File: bar_decode_pkg.sv
/*
  package for the bar aperture decoder: register map, field layout, reset values,
  aperture limits and the request/answer carriers.
  assumes a 32-bit ahb-lite register bus and a 64-bit request address.
*/
package bar_decode_pkg;

  localparam int NUM_BARS = 6;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROM_CFG = 8'h04;
  localparam logic [7:0] OFS_ROM_BASE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_BAR_CFG0 = 8'h10;
  localparam logic [7:0] OFS_BAR_LO0 = 8'h30;
  localparam logic [7:0] OFS_BAR_HI0 = 8'h50;
  localparam logic [7:0] OFS_ID = 8'h70;

  // control fields
  localparam int CTRL_ROOT_BIT = 0;
  localparam int CTRL_LEGACY_BIT = 1;

  // bar config fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_IO_BIT = 1;
  localparam int CFG_64_BIT = 2;
  localparam int CFG_PREF_BIT = 3;
  localparam int CFG_SIZE_LSB = 8;

  // aperture limits as log2 of bytes
  localparam logic [5:0] LOG2_MIN_LEGACY = 6'd4;
  localparam logic [5:0] LOG2_MIN_STD = 6'd7;
  localparam logic [5:0] LOG2_MAX_32 = 6'd31;
  localparam logic [5:0] LOG2_MAX_64 = 6'd63;
  localparam logic [5:0] LOG2_ROM_MIN = 6'd11;
  localparam logic [5:0] LOG2_ROM_MAX = 6'd32;
  localparam logic [5:0] LOG2_ROM_ADVISED = 6'd24;
  localparam logic [5:0] LOG2_ADVISED_MEM = 6'd12;

  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_BAR_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // identity value is arbitrary
  localparam logic [31:0] BLOCK_ID = 32'h0000_B4A5;

  // answer codes for a rom claim and for an unclaimed request
  localparam logic [2:0] HIT_ROM = 3'd6;
  localparam logic [2:0] HIT_NONE = 3'd7;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [63:0] addr;
  } req_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [2:0] bar_id;
  } resp_s;

endpackage : bar_decode_pkg

// File: bar_aperture_decode.sv
/*
  bar aperture decoder with ahb-lite register slave: holds six bar settings and an
  expansion rom bar, and claims incoming requests one cycle after they arrive.
  assumes the request path is synchronous to hclk and ahb single word transfers.
*/
// Operation
// - endpoint: six 32-bit or three 64-bit bars, rom
// - root port: two 32-bit or one 64-bit; the code also lets bar1 be 64-bit beside a 32-bit bar0
// - 64-bit bar consumes next bar as upper half
// - io bars 32-bit, no prefetch, legacy only
// - 32-bit up to 2 GB, 64-bit memory only
// - minimum memory aperture 128 B, legacy 16 B
// - io aperture at least 16 bytes
// - bar claims only its own space type
// - non-legacy prefetchable bars except bar5 are 64-bit
// - non-prefetchable bars may stay 32-bit
// - rom aperture 2 KB to 4 GB
// - disabled bar claims nothing
// - memory below 4 KB flagged, still allowed
`timescale 1ns/1ps
module bar_aperture_decode (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire bar_decode_pkg::req_s req,
  output bar_decode_pkg::resp_s resp
);
  import bar_decode_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] rom_cfg;
  logic [31:0] rom_base;
  logic [31:0] bar_cfg [NUM_BARS];
  logic [31:0] bar_lo [NUM_BARS];
  logic [31:0] bar_hi [NUM_BARS];
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_req;
  logic wr_req;
  logic root_mode;
  logic legacy_mode;
  logic [5:0] min_size;
  logic [NUM_BARS-1:0] raw_en;
  logic [NUM_BARS-1:0] eff_en;
  logic [NUM_BARS-1:0] eff_io;
  logic [NUM_BARS-1:0] eff_64;
  logic [NUM_BARS-1:0] small_mem;
  logic [5:0] eff_size [NUM_BARS];
  logic [63:0] eff_mask [NUM_BARS];
  logic [63:0] eff_base [NUM_BARS];
  logic [NUM_BARS-1:0] bar_hit;
  logic [5:0] rom_size;
  logic [63:0] rom_mask;
  logic rom_big;
  logic rom_hit;
  logic [2:0] next_bar_id;
  logic next_hit;
  logic [31:0] status_word;
  logic [31:0] next_hrdata;

  // mask of address bits at and above the aperture size
  function automatic logic [63:0] size_mask(input logic [5:0] log2);
    size_mask = ~((64'h1 << log2) - 64'h1);
  endfunction : size_mask

  function automatic logic [5:0] clamp(input logic [5:0] v, input logic [5:0] lo, input logic [5:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // request lies below 4 GB
  function automatic logic upper_zero(input logic [63:0] a);
    upper_zero = (a[63:32] == 32'h0000_0000);
  endfunction : upper_zero

  // size field of a bar or rom config word
  function automatic logic [5:0] field_size(input logic [31:0] cfg);
    field_size = cfg[CFG_SIZE_LSB +: 6];
  endfunction : field_size

  // register of index idx in a bank of word registers
  function automatic logic reg_at(input logic [7:0] addr, input logic [7:0] first, input int idx);
    reg_at = (addr == (first + 8'(4 * idx)));
  endfunction : reg_at

  // global mode bits
  always_comb begin
    root_mode = ctrl[CTRL_ROOT_BIT];
    legacy_mode = ctrl[CTRL_LEGACY_BIT];
    min_size = legacy_mode ? LOG2_MIN_LEGACY : LOG2_MIN_STD;
  end

  // per-bar enable before the 64-bit pairing is applied
  always_comb begin
    for (int i = 0; i < NUM_BARS; i++) begin
      raw_en[i] = bar_cfg[i][CFG_EN_BIT];
      if (root_mode && i >= 2) begin
        raw_en[i] = 1'b0;
      end
      if (bar_cfg[i][CFG_64_BIT] && !bar_cfg[i][CFG_IO_BIT] && i == NUM_BARS - 1) begin
        raw_en[i] = 1'b0;
      end
    end
  end

  // io and 64-bit decode of each bar
  always_comb begin
    for (int i = 0; i < NUM_BARS; i++) begin
      eff_io[i] = bar_cfg[i][CFG_IO_BIT] && legacy_mode;
      eff_64[i] = 1'b0;
      if (!eff_io[i] && i < NUM_BARS - 1) begin
        if (bar_cfg[i][CFG_64_BIT]) begin
          eff_64[i] = 1'b1;
        end
        if (bar_cfg[i][CFG_PREF_BIT] && !legacy_mode) begin
          eff_64[i] = 1'b1;
        end
      end
    end
  end

  // the bar above an enabled 64-bit bar is disabled, the upper base half comes from bar_hi of the 64-bit bar
  always_comb begin
    logic upper_taken;
    upper_taken = 1'b0;
    for (int i = 0; i < NUM_BARS; i++) begin
      eff_en[i] = raw_en[i] && !upper_taken;
      upper_taken = eff_en[i] && eff_64[i];
    end
  end

  // aperture size and mask of each bar
  always_comb begin
    for (int i = 0; i < NUM_BARS; i++) begin
      if (eff_64[i]) begin
        eff_size[i] = clamp(field_size(bar_cfg[i]), min_size, LOG2_MAX_64);
      end else begin
        eff_size[i] = clamp(field_size(bar_cfg[i]), min_size, LOG2_MAX_32);
      end
      eff_mask[i] = size_mask(eff_size[i]);
      small_mem[i] = eff_en[i] && !eff_io[i] && (eff_size[i] < LOG2_ADVISED_MEM);
    end
  end

  // programmed base of each bar
  always_comb begin
    for (int i = 0; i < NUM_BARS; i++) begin
      if (eff_64[i]) begin
        eff_base[i] = {bar_hi[i], bar_lo[i]};
      end else begin
        eff_base[i] = {32'h0000_0000, bar_lo[i]};
      end
    end
  end

  // address claim per bar
  always_comb begin
    for (int i = 0; i < NUM_BARS; i++) begin
      bar_hit[i] = eff_en[i]
                   && (eff_io[i] == req.is_io)
                   && (eff_64[i] || upper_zero(req.addr))
                   && ((req.addr & eff_mask[i]) == (eff_base[i] & eff_mask[i]));
    end
  end

  // expansion rom claim
  always_comb begin
    rom_size = clamp(field_size(rom_cfg), LOG2_ROM_MIN, LOG2_ROM_MAX);
    rom_mask = size_mask(rom_size);
    rom_big = rom_cfg[CFG_EN_BIT] && (field_size(rom_cfg) > LOG2_ROM_ADVISED);
    rom_hit = rom_cfg[CFG_EN_BIT] && !req.is_io && upper_zero(req.addr)
              && ((req.addr & rom_mask) == ({32'h0000_0000, rom_base} & rom_mask));
  end

  // lowest numbered hit wins
  always_comb begin
    next_hit = 1'b0;
    next_bar_id = HIT_NONE;
    for (int i = NUM_BARS - 1; i >= 0; i--) begin
      if (bar_hit[i]) begin
        next_hit = 1'b1;
        next_bar_id = 3'(i);
      end
    end
    if (!next_hit && rom_hit) begin
      next_hit = 1'b1;
      next_bar_id = HIT_ROM;
    end
  end

  // registered answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp <= '0;
    end else begin
      resp.valid <= req.valid;
      resp.hit <= req.valid && next_hit;
      resp.bar_id <= req.valid ? next_bar_id : HIT_NONE;
    end
  end

  // ahb address phase decode
  always_comb begin
    rd_req = hready && hsel && htrans[1] && !hwrite;
    wr_req = hready && hsel && htrans[1] && hwrite;
  end

  // pending write flag for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
    end else if (hready) begin
      wr_pend <= wr_req;
    end
  end

  // captured write address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_addr <= haddr[7:0];
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= RST_CTRL;
    end else if (wr_pend && wr_addr == OFS_CTRL) begin
      ctrl <= hwdata & 32'h0000_0003;
    end
  end

  // rom config register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_cfg <= RST_ZERO;
    end else if (wr_pend && wr_addr == OFS_ROM_CFG) begin
      rom_cfg <= hwdata & 32'h0000_3F01;
    end
  end

  // rom base register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rom_base <= RST_ZERO;
    end else if (wr_pend && wr_addr == OFS_ROM_BASE) begin
      rom_base <= hwdata;
    end
  end

  // bar config bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_BARS; i++) begin
        bar_cfg[i] <= RST_BAR_CFG;
      end
    end else if (wr_pend) begin
      for (int i = 0; i < NUM_BARS; i++) begin
        if (reg_at(wr_addr, OFS_BAR_CFG0, i)) begin
          bar_cfg[i] <= hwdata & 32'h0000_3F0F;
        end
      end
    end
  end

  // bar lower base bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_BARS; i++) begin
        bar_lo[i] <= RST_ZERO;
      end
    end else if (wr_pend) begin
      for (int i = 0; i < NUM_BARS; i++) begin
        if (reg_at(wr_addr, OFS_BAR_LO0, i)) begin
          bar_lo[i] <= hwdata;
        end
      end
    end
  end

  // bar upper base bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_BARS; i++) begin
        bar_hi[i] <= RST_ZERO;
      end
    end else if (wr_pend) begin
      for (int i = 0; i < NUM_BARS; i++) begin
        if (reg_at(wr_addr, OFS_BAR_HI0, i)) begin
          bar_hi[i] <= hwdata;
        end
      end
    end
  end

  // status word
  always_comb begin
    status_word = {13'h0, rom_big, small_mem, eff_64, eff_en};
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    next_hrdata = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: next_hrdata = ctrl;
      OFS_ROM_CFG: next_hrdata = rom_cfg;
      OFS_ROM_BASE: next_hrdata = rom_base;
      OFS_STATUS: next_hrdata = status_word;
      OFS_ID: next_hrdata = BLOCK_ID;
      default: begin
        for (int i = 0; i < NUM_BARS; i++) begin
          if (reg_at(haddr[7:0], OFS_BAR_CFG0, i)) begin
            next_hrdata = bar_cfg[i];
          end
          if (reg_at(haddr[7:0], OFS_BAR_LO0, i)) begin
            next_hrdata = bar_lo[i] & eff_mask[i][31:0];
          end
          if (reg_at(haddr[7:0], OFS_BAR_HI0, i)) begin
            next_hrdata = bar_hi[i];
          end
        end
      end
    endcase
  end

  // read data loaded in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata <= next_hrdata;
    end
  end

  // no wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // response is always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

endmodule : bar_aperture_decode

// File: req_model.sv
/* request path model: issues one request per call
   assumes the bench calls send just after a rising edge */
`timescale 1ns/1ps
module req_model (
  input wire logic hclk,
  output bar_decode_pkg::req_s req
);
  import bar_decode_pkg::*;
  initial req = '0;
  // merging of byte writes is never attempted, each request stands alone
  task automatic send(input logic io, input logic [63:0] a);
    req <= '{1'b1, io, a};
    @(posedge hclk);
    req <= '{1'b0, ~io, ~a};
  endtask : send
endmodule : req_model

// File: bar_aperture_decode_sva.sv
/* port assertions for the decoder
   assumes a single hclk domain */
`timescale 1ns/1ps
module bar_decode_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire bar_decode_pkg::req_s req,
  input wire bar_decode_pkg::resp_s resp
);
  import bar_decode_pkg::*;
  logic aw, leg, root;
  logic [7:0] aa;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {aw, aa, leg, root} <= '0;
    end else begin
      if (aw && aa == OFS_CTRL) {leg, root} <= hwdata[1:0];
      if (hready) {aw, aa} <= {hsel && htrans[1] && hwrite, haddr[7:0]};
    end
  end
  resp_follow_a: assert property (resp.valid == $past(req.valid))
    else $error("resp valid late");
  hit_code_a: assert property (resp.hit |-> resp.valid && resp.bar_id != HIT_NONE)
    else $error("hit code bad");
  miss_code_a: assert property (resp.valid && !resp.hit |-> resp.bar_id == HIT_NONE)
    else $error("miss code bad");
  io_legacy_a: assert property (!$past(leg) && $past(req.valid && req.is_io) |-> !resp.hit)
    else $error("io hit non legacy");
  io_rom_a: assert property ($past(req.valid && req.is_io) && resp.hit |-> resp.bar_id != HIT_ROM)
    else $error("io hit rom");
  io_upper_a: assert property ($past(req.valid && req.is_io && req.addr[63:32] != 0) |-> !resp.hit)
    else $error("io hit above 4G");
  root_bars_a: assert property ($past(root) && resp.hit |-> resp.bar_id < 3'h2 || resp.bar_id == HIT_ROM)
    else $error("root bar hit");
  unmapped_a: assert property (hready && hsel && htrans[1] && !hwrite && haddr[7:0] > OFS_ID |=> hrdata == RST_ZERO)
    else $error("unmapped read");
  io_hit_c: cover property ($past(req.valid && req.is_io) && resp.hit);
  rom_hit_c: cover property (resp.hit && resp.bar_id == HIT_ROM);
  pair_hit_c: cover property (resp.hit && resp.bar_id == 3'h2);
endmodule : bar_decode_sva
bind bar_aperture_decode bar_decode_sva sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .req, .resp);

// File: tb_bar_aperture_decode.sv
/* bench for the decoder: ahb tasks, request probes, verdict
   assumes req_model on the request side */
`timescale 1ns/1ps
module tb_bar_aperture_decode;
  import bar_decode_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  req_s req;
  resp_s resp;
  int error_cnt, n_compared, cyc;
  bar_aperture_decode dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req, .resp);
  req_model pm (.hclk, .req);
  always #5 hclk = ~hclk;
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("reg", q, e);
  endtask : rc
  task automatic pr(input logic io, input logic [63:0] a, input logic [2:0] id);
    pm.send(io, a);
    #1;
    chk("resp", 32'({resp.valid, resp.hit, resp.bar_id}), 32'({1'b1, id != HIT_NONE, id}));
    @(posedge hclk);
  endtask : pr
  task automatic t_mem;
    rc(OFS_CTRL, RST_CTRL);
    rc(8'h80, RST_ZERO);
    pr(1'b0, 64'h0, HIT_NONE);
    wr(OFS_BAR_CFG0, 32'h0C01);
    wr(OFS_BAR_LO0, 32'h0001_0000);
    pr(1'b0, 64'h0001_0FFC, 3'h0);
    pr(1'b0, 64'h0001_1000, HIT_NONE);
    pr(1'b0, 64'h1_0001_0000, HIT_NONE);
    pr(1'b1, 64'h0001_0000, HIT_NONE);
  endtask : t_mem
  task automatic t_pair;
    wr(OFS_BAR_CFG0 + 8'h08, 32'h1405);
    wr(OFS_BAR_LO0 + 8'h08, 32'h0010_0000);
    wr(OFS_BAR_HI0 + 8'h08, 32'h1);
    wr(OFS_BAR_CFG0 + 8'h0C, 32'h0C01);
    wr(OFS_BAR_LO0 + 8'h0C, 32'h0020_0000);
    pr(1'b0, 64'h1_0010_0004, 3'h2);
    pr(1'b0, 64'h0020_0000, HIT_NONE);
    rc(OFS_STATUS, 32'h105);
  endtask : t_pair
  task automatic t_pref;
    wr(OFS_BAR_CFG0 + 8'h10, 32'h0C09);
    wr(OFS_BAR_LO0 + 8'h10, 32'h0030_0000);
    pr(1'b0, 64'h0030_0000, 3'h4);
    rc(OFS_STATUS, 32'h515);
    wr(OFS_BAR_CFG0, 32'h0401);
    pr(1'b0, 64'h0001_0040, 3'h0);
    pr(1'b0, 64'h0001_0080, HIT_NONE);
    rc(OFS_STATUS, 32'h1515);
  endtask : t_pref
  task automatic t_legacy;
    wr(OFS_CTRL, 32'h2);
    wr(OFS_BAR_CFG0 + 8'h04, 32'h0403);
    wr(OFS_BAR_LO0 + 8'h04, 32'h0040_0000);
    pr(1'b1, 64'h0040_000C, 3'h1);
    pr(1'b1, 64'h0040_0010, HIT_NONE);
    pr(1'b1, 64'h1_0040_000C, HIT_NONE);
    pr(1'b0, 64'h0040_0000, HIT_NONE);
    pr(1'b0, 64'h0001_0010, HIT_NONE);
  endtask : t_legacy
  task automatic t_rom_root;
    wr(OFS_ROM_CFG, 32'h0B01);
    wr(OFS_ROM_BASE, 32'h8000_0000);
    pr(1'b0, 64'h8000_07FC, HIT_ROM);
    pr(1'b0, 64'h8000_0800, HIT_NONE);
    wr(OFS_CTRL, 32'h1);
    pr(1'b0, 64'h1_0010_0004, HIT_NONE);
    pr(1'b0, 64'h0001_0000, 3'h0);
    wr(OFS_BAR_CFG0 + 8'h04, 32'h3F01);
    wr(OFS_BAR_LO0 + 8'h04, 32'h8000_0000);
    pr(1'b0, 64'h0000_1000, HIT_NONE);
    pr(1'b0, 64'hC000_0000, 3'h1);
  endtask : t_rom_root
  initial begin
    {hclk, hresetn, hsel, hwrite, hsize, haddr, hwdata, htrans} = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_mem;
    t_pair;
    t_pref;
    t_legacy;
    t_rom_root;
    end_sim;
  end
endmodule : tb_bar_aperture_decode
